//--- verilog/dte_ctl_pkg.sv
package dte_ctl_pkg;

  // ==========================================================
  // register offsets (word index = byte address / 4)
  // ==========================================================
  localparam logic [7:0] ADDR_DCD_CFG  = 8'h00;
  localparam logic [7:0] ADDR_CTS_CFG  = 8'h04;
  localparam logic [7:0] ADDR_MISC_CFG = 8'h08;
  localparam logic [7:0] ADDR_LOOP_CMD = 8'h0c;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  localparam logic [7:0] ADDR_RATE_CFG = 8'h14;

  // ==========================================================
  // field positions
  // ==========================================================
  localparam int DCD_MODE_LSB   = 0;  // [1:0]
  localparam int DCD_DLY_LSB    = 8;  // [14:8] requested bits
  localparam int CTS_MODE_LSB   = 0;  // [1:0]
  localparam int CTS_UNIT_BIT   = 2;  // 1 = milliseconds
  localparam int CTS_DLY_LSB    = 8;  // [16:8] requested value
  localparam int DSR_ON_BIT     = 0;
  localparam int RATE_EXACT_BIT = 1;
  localparam int RI_EN_BIT      = 2;
  localparam int LL_PERMIT_BIT  = 3;
  localparam int CONSOLE_BIT    = 4;
  localparam int CHAR_LSB       = 8;  // [10:8]
  localparam int NET_LOOP_BIT   = 0;
  localparam int TIMER_ON_BIT   = 1;

  // ==========================================================
  // modes
  // ==========================================================
  typedef enum logic [1:0] {
    SIG_OFF   = 2'b00,
    SIG_ON    = 2'b01,
    SIG_TRACK = 2'b10
  } sig_mode_t;

  typedef enum logic [2:0] {
    FRAME_SYNC   = 3'b000,
    FRAME_ASYNC_EIGHT_BIT_CHAR   = 3'b001,
    FRAME_ASY9   = 3'b010,
    FRAME_ASY10  = 3'b011,
    FRAME_ASY11  = 3'b100
  } frame_t;

  typedef enum logic [1:0] {
    LOOP_NONE    = 2'b00,
    LOOP_LOC     = 2'b01,
    LOOP_NET     = 2'b10,
    LOOP_LOC_NET = 2'b11
  } loop_dir_t;

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [31:0] RST_DCD_CFG  = 32'h0000_0501;
  localparam logic [31:0] RST_CTS_CFG  = 32'h0000_0001;
  localparam logic [31:0] RST_MISC_CFG = 32'h0000_0019;
  localparam logic [31:0] RST_LOOP_CMD = 32'h0000_0002;
  localparam logic [15:0] RST_BIT_DIV  = 16'h0682;

  // ==========================================================
  // timing
  // ==========================================================
  localparam int CLK_HZ          = 100_000_000;
  localparam int DCD_STEP_BITS   = 5;
  localparam int DCD_MIN_BITS    = 5;
  localparam int DCD_MAX_BITS    = 80;
  localparam int CTS_STEP_BITS   = 10;
  localparam int CTS_MAX_BITS    = 60;
  localparam int MS_PER_SEC      = 1000;
  localparam int MS_CYCLES       = CLK_HZ / MS_PER_SEC;
  localparam int LOOP_TIMEOUT_MIN = 15;
  localparam int SEC_PER_MIN     = 60;
  localparam int LOOP_TIMEOUT_MS =
    LOOP_TIMEOUT_MIN * SEC_PER_MIN * MS_PER_SEC;

endpackage : dte_ctl_pkg

//--- verilog/dte_control_signal_loopback.sv
// What this block does
// - dcd forced off, forced on by default, or tracks far-end rts
// - carrier off delay used only in tracking, 5..80 bits, step 5
// - carrier off delay request rounds up to next 5-bit step
// - dsr forced off or forced on, on by default
// - cts forced off, forced on by default, or follows local rts
// - clear on delay only in following, 0..60 bits, step 10
// - clear on delay may be 10,20,30,40,50,100,250 ms
// - clear on delay request rounds up to next step of its unit
// - async rate mode offset by default, or exact
// - ring indicator output enabled or disabled, disabled by default
// - dte remote loop requests always ignored, never looped
// - dte local loop requests accepted only when permitted, default on
// - front-panel switch forces local loop regardless of permit
// - console view read-only when enabled by default, else nothing
// - line card commands network loop, default none
// - timer on by default ends active loop after 15 minutes, except a switch-made local loop
// - loop direction status none, local, network or both
// - manual local loop shows as local or local plus network
// - sync or async character lengths of 8, 9, 10 or 11 bits
module dte_control_signal_loopback
  import dte_ctl_pkg::*;
#(
  parameter int LOOP_TIMEOUT_MS_P = LOOP_TIMEOUT_MS, // shorten in sim
  parameter int MS_CYCLES_P       = MS_CYCLES        // shorten in sim
)(
  input  wire logic        clk_sys,        // 100 mhz
  input  wire logic        sys_rst,        // sync, active high
  input  wire logic [7:0]  reg_addr,       // byte address
  input  wire logic [31:0] reg_wdata,      // write data
  input  wire logic        reg_wr,         // write strobe
  input  wire logic        reg_rd,         // read strobe
  output logic      [31:0] reg_rdata,      // data one cycle after rd
  input  wire logic        far_rts,        // rts signalled by far end
  input  wire logic        dte_rts,        // local dte rts pin
  input  wire logic        dte_ll_req,     // dte local loop request pin
  input  wire logic        dte_rl_req,     // dte remote loop request pin
  input  wire logic        panel_ll_sw,    // front-panel loop switch
  input  wire logic        ring_det,       // ring event from line
  output logic             dte_dcd,        // carrier detect to dte
  output logic             dte_dsr,        // data set ready to dte
  output logic             dte_cts,        // clear to send to dte
  output logic             dte_ri,         // ring indicator to dte
  output logic             local_loop,     // close loop unit-dte
  output logic             net_loop,       // close loop line card-unit
  output logic             remote_loop,    // loop dte-line card
  output logic             console_en,     // rear console view enable
  output logic             rate_exact,     // async rate generation
  output logic      [2:0]  char_frame,     // framing / char length
  output logic             bit_tick        // one pulse per bit time
);

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic [5:0] meta_ff;
  logic [5:0] sync_ff;
  wire  [5:0] pins_in = {ring_det, panel_ll_sw, dte_rl_req,
                         dte_ll_req, dte_rts, far_rts};

  always_ff @(posedge clk_sys)
  begin
    meta_ff <= pins_in;
    sync_ff <= meta_ff;
  end

  wire far_rts_s = sync_ff[0];
  wire dte_rts_s = sync_ff[1];
  wire ll_req_s  = sync_ff[2];
  wire rl_req_s  = sync_ff[3];
  wire panel_s   = sync_ff[4];
  wire ring_s    = sync_ff[5];

  // ==========================================================
  // registers
  // ==========================================================
  logic [31:0] dcd_cfg_ff;
  logic [31:0] cts_cfg_ff;
  logic [31:0] misc_cfg_ff;
  logic [31:0] loop_cmd_ff;
  logic [15:0] bit_div_ff;

  wire wr_dcd  = reg_wr && (reg_addr == ADDR_DCD_CFG);
  wire wr_cts  = reg_wr && (reg_addr == ADDR_CTS_CFG);
  wire wr_misc = reg_wr && (reg_addr == ADDR_MISC_CFG);
  wire wr_loop = reg_wr && (reg_addr == ADDR_LOOP_CMD);
  wire wr_rate = reg_wr && (reg_addr == ADDR_RATE_CFG);

  // timer indication is read-only: writes keep it
  wire [31:0] nxt_loop_cmd = {30'h0, loop_cmd_ff[TIMER_ON_BIT],
                              reg_wdata[NET_LOOP_BIT]};

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      dcd_cfg_ff  <= RST_DCD_CFG;
      cts_cfg_ff  <= RST_CTS_CFG;
      misc_cfg_ff <= RST_MISC_CFG;
      loop_cmd_ff <= RST_LOOP_CMD;
      bit_div_ff  <= RST_BIT_DIV;
    end
    else
    begin
      if (wr_dcd)  dcd_cfg_ff  <= reg_wdata;
      if (wr_cts)  cts_cfg_ff  <= reg_wdata;
      if (wr_misc) misc_cfg_ff <= reg_wdata;
      if (wr_loop) loop_cmd_ff <= nxt_loop_cmd;
      if (wr_rate) bit_div_ff  <= reg_wdata[15:0];
    end
  end

  wire [1:0] dcd_mode = dcd_cfg_ff[DCD_MODE_LSB +: 2];
  wire [6:0] dcd_req  = dcd_cfg_ff[DCD_DLY_LSB +: 7];
  wire [1:0] cts_mode = cts_cfg_ff[CTS_MODE_LSB +: 2];
  wire       cts_ms   = cts_cfg_ff[CTS_UNIT_BIT];
  wire [8:0] cts_req  = cts_cfg_ff[CTS_DLY_LSB +: 9];
  wire       timer_on = loop_cmd_ff[TIMER_ON_BIT];

  // ==========================================================
  // delay rounding
  // ==========================================================
  // round up to a multiple of 5, clamp to 5..80
  wire [7:0] dcd_up  = 8'(dcd_req) + 8'(DCD_STEP_BITS - 1);
  wire [7:0] dcd_rnd = dcd_up - 8'(dcd_up % 8'(DCD_STEP_BITS));
  wire [7:0] dcd_bits =
    (dcd_rnd < 8'(DCD_MIN_BITS)) ? 8'(DCD_MIN_BITS) :
    (dcd_rnd > 8'(DCD_MAX_BITS)) ? 8'(DCD_MAX_BITS) : dcd_rnd;

  wire [9:0] cts_up  = 10'(cts_req) + 10'(CTS_STEP_BITS - 1);
  wire [9:0] cts_rnd = cts_up - 10'(cts_up % 10'(CTS_STEP_BITS));
  wire [9:0] cts_bits =
    (cts_rnd > 10'(CTS_MAX_BITS)) ? 10'(CTS_MAX_BITS) : cts_rnd;
  wire [9:0] cts_msv =
    (cts_req <= 9'd10)  ? 10'd10  :
    (cts_req <= 9'd20)  ? 10'd20  :
    (cts_req <= 9'd30)  ? 10'd30  :
    (cts_req <= 9'd40)  ? 10'd40  :
    (cts_req <= 9'd50)  ? 10'd50  :
    (cts_req <= 9'd100) ? 10'd100 : 10'd250;
  wire [9:0] cts_target = cts_ms ? cts_msv : cts_bits;

  // ==========================================================
  // timebases
  // ==========================================================
  logic [15:0] bit_cnt_ff;
  logic [16:0] ms_cnt_ff;
  logic        bit_tick_ff;
  logic        ms_tick_ff;
  wire bit_wrap = (bit_cnt_ff >= bit_div_ff);
  wire ms_wrap  = (ms_cnt_ff == 17'(MS_CYCLES_P - 1));

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      bit_cnt_ff  <= 16'h0000;
      ms_cnt_ff   <= 17'h00000;
      bit_tick_ff <= 1'b0;
      ms_tick_ff  <= 1'b0;
    end
    else
    begin
      bit_cnt_ff  <= bit_wrap ? 16'h0000 : bit_cnt_ff + 16'h0001;
      ms_cnt_ff   <= ms_wrap ? 17'h00000 : ms_cnt_ff + 17'h00001;
      bit_tick_ff <= bit_wrap;
      ms_tick_ff  <= ms_wrap;
    end
  end

  // ==========================================================
  // carrier_off_delay on far rts fall
  // ==========================================================
  logic       far_rts_q_ff;
  logic [7:0] dcd_cnt_ff;
  logic       dcd_trk_ff;
  wire far_fall = far_rts_q_ff && !far_rts_s;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      far_rts_q_ff <= 1'b0;
      dcd_cnt_ff   <= 8'h00;
      dcd_trk_ff   <= 1'b0;
    end
    else
    begin
      far_rts_q_ff <= far_rts_s;
      if (far_rts_s)
      begin
        dcd_trk_ff <= 1'b1;
        dcd_cnt_ff <= 8'h00;
      end
      else if (far_fall)
        dcd_cnt_ff <= 8'h00;
      else if (dcd_trk_ff && bit_tick_ff)
      begin
        if (dcd_cnt_ff + 8'h01 >= dcd_bits)
          dcd_trk_ff <= 1'b0;
        dcd_cnt_ff <= dcd_cnt_ff + 8'h01;
      end
    end
  end

  wire nxt_dcd = (dcd_mode == SIG_ON) ? 1'b1 :
                 (dcd_mode == SIG_TRACK) ? dcd_trk_ff : 1'b0;

  // ==========================================================
  // cts: on-delay after local rts rise
  // ==========================================================
  logic [9:0] cts_cnt_ff;
  logic       cts_trk_ff;
  wire cts_tick = cts_ms ? ms_tick_ff : bit_tick_ff;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cts_cnt_ff <= 10'h000;
      cts_trk_ff <= 1'b0;
    end
    else if (!dte_rts_s)
    begin
      cts_cnt_ff <= 10'h000;
      cts_trk_ff <= 1'b0;
    end
    else if (!cts_trk_ff)
    begin
      if (cts_cnt_ff >= cts_target)
        cts_trk_ff <= 1'b1;
      else if (cts_tick)
        cts_cnt_ff <= cts_cnt_ff + 10'h001;
    end
  end

  wire nxt_cts = (cts_mode == SIG_ON) ? 1'b1 :
                 (cts_mode == SIG_TRACK) ? cts_trk_ff : 1'b0;

  // ==========================================================
  // loops and loop timeout
  // ==========================================================
  wire ll_permit = misc_cfg_ff[LL_PERMIT_BIT];
  wire loc_act   = panel_s || (ll_permit && ll_req_s);
  logic        loc_q_ff;
  logic        net_q_ff;
  logic        loop_expired_ff;
  logic [23:0] to_cnt_ff;
  wire net_act  = loop_cmd_ff[NET_LOOP_BIT];
  wire any_loop = loc_act || net_act;
  wire loop_new = (loc_act && !loc_q_ff) || (net_act && !net_q_ff);
  // switch-made loop is never timed out by the hardware
  wire loc_live = panel_s || (loc_act && !loop_expired_ff);
  wire net_live = net_act && !loop_expired_ff;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      loc_q_ff        <= 1'b0;
      net_q_ff        <= 1'b0;
      loop_expired_ff <= 1'b0;
      to_cnt_ff       <= 24'h000000;
    end
    else
    begin
      loc_q_ff <= loc_act;
      net_q_ff <= net_act;
      if (!any_loop || loop_new)
      begin
        to_cnt_ff       <= 24'h000000;
        loop_expired_ff <= 1'b0;
      end
      else if (timer_on && ms_tick_ff && !loop_expired_ff)
      begin
        if (to_cnt_ff + 24'h000001 >= 24'(LOOP_TIMEOUT_MS_P))
          loop_expired_ff <= 1'b1;
        to_cnt_ff <= to_cnt_ff + 24'h000001;
      end
    end
  end

  wire [1:0] loop_dir = {net_live, loc_live};

  // ==========================================================
  // outputs
  // ==========================================================
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      dte_dcd     <= 1'b1;
      dte_dsr     <= 1'b1;
      dte_cts     <= 1'b1;
      dte_ri      <= 1'b0;
      local_loop  <= 1'b0;
      net_loop    <= 1'b0;
      remote_loop <= 1'b0;
      console_en  <= 1'b1;
      rate_exact  <= 1'b0;
      char_frame  <= FRAME_SYNC;
      bit_tick    <= 1'b0;
    end
    else
    begin
      dte_dcd     <= nxt_dcd;
      dte_dsr     <= misc_cfg_ff[DSR_ON_BIT];
      dte_cts     <= nxt_cts;
      dte_ri      <= misc_cfg_ff[RI_EN_BIT] && ring_s;
      local_loop  <= loc_live;
      net_loop    <= net_live;
      remote_loop <= 1'b0;
      console_en  <= misc_cfg_ff[CONSOLE_BIT];
      rate_exact  <= misc_cfg_ff[RATE_EXACT_BIT];
      char_frame  <= (misc_cfg_ff[CHAR_LSB +: 3] > FRAME_ASY11) ?
                     FRAME_SYNC : misc_cfg_ff[CHAR_LSB +: 3];
      bit_tick    <= bit_tick_ff;
    end
  end

  // ==========================================================
  // read path
  // ==========================================================
  wire [31:0] status_word = {20'h0, 1'b0, rl_req_s, ll_req_s,
                             panel_s, dte_rts_s, far_rts_s,
                             dte_dcd, dte_cts, loop_expired_ff,
                             timer_on, loop_dir};
  wire [31:0] rd_mux =
    (reg_addr == ADDR_DCD_CFG)  ? dcd_cfg_ff  :
    (reg_addr == ADDR_CTS_CFG)  ? cts_cfg_ff  :
    (reg_addr == ADDR_MISC_CFG) ? misc_cfg_ff :
    (reg_addr == ADDR_LOOP_CMD) ? loop_cmd_ff :
    (reg_addr == ADDR_STATUS)   ? status_word :
    (reg_addr == ADDR_RATE_CFG) ? {16'h0, bit_div_ff} : 32'h0;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      reg_rdata <= 32'h0;
    else if (reg_rd)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= 32'h0;
  end

endmodule : dte_control_signal_loopback

//--- testbench/dte_ctl_chk_sva.sv
module dte_ctl_chk
  import dte_ctl_pkg::*;
#(
  parameter int LOOP_TIMEOUT_MS_P = LOOP_TIMEOUT_MS, // timeout ms
  parameter int MS_CYCLES_P       = MS_CYCLES        // clocks per ms
)(
  input wire logic        clk_sys,     // clock
  input wire logic        sys_rst,     // reset
  input wire logic [7:0]  reg_addr,    // address
  input wire logic [31:0] reg_wdata,   // write data
  input wire logic        reg_wr,      // write strobe
  input wire logic        reg_rd,      // read strobe
  input wire logic [31:0] reg_rdata,   // read data
  input wire logic        far_rts,     // far rts
  input wire logic        dte_rts,     // local rts
  input wire logic        panel_ll_sw, // panel switch
  input wire logic        ring_det,    // ring event
  input wire logic        dte_dcd,     // carrier
  input wire logic        dte_dsr,     // set ready
  input wire logic        dte_cts,     // clear to send
  input wire logic        dte_ri,      // ring out
  input wire logic        local_loop,  // local loop
  input wire logic        net_loop,    // network loop
  input wire logic        remote_loop, // remote loop
  input wire logic        console_en,  // console view
  input wire logic        rate_exact,  // rate mode
  input wire logic [2:0]  char_frame   // framing
);
  // ==========================================================
  // shadow of the written configuration
  // ==========================================================
  logic [10:0] misc_ff;
  logic [1:0]  dcd_ff;
  logic [1:0]  cts_ff;
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      misc_ff <= RST_MISC_CFG[10:0];
      dcd_ff  <= RST_DCD_CFG[1:0];
      cts_ff  <= RST_CTS_CFG[1:0];
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_MISC_CFG) misc_ff <= reg_wdata[10:0];
      if (reg_addr == ADDR_DCD_CFG) dcd_ff <= reg_wdata[1:0];
      if (reg_addr == ADDR_CTS_CFG) cts_ff <= reg_wdata[1:0];
    end
  end
  // ==========================================================
  // properties
  // ==========================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_remote_never: assert property (!remote_loop)
    else $error("remote loop closed");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  a_panel_loop: assert property (panel_ll_sw [*5] |-> local_loop)
    else $error("panel switch did not close local loop");
  a_ll_permit: assert property ((!misc_ff[3] && !panel_ll_sw) [*5]
    |-> !local_loop) else $error("local loop without permit");
  a_ri_gate: assert property ($stable({misc_ff[2], ring_det}) [*5]
    |-> dte_ri == (misc_ff[2] && ring_det)) else $error("ring output");
  a_dsr_cfg: assert property ($stable(misc_ff) [*3]
    |-> dte_dsr == misc_ff[0] && rate_exact == misc_ff[1]
    && console_en == misc_ff[4]) else $error("misc outputs");
  a_frame_cfg: assert property ($stable(misc_ff) [*3]
    |-> char_frame == ((misc_ff[10:8] > FRAME_ASY11) ? FRAME_SYNC
    : misc_ff[10:8])) else $error("char frame");
  a_dcd_forced: assert property ($stable(dcd_ff) [*3]
    ##0 dcd_ff != 2'b10 |-> dte_dcd == (dcd_ff == 2'b01))
    else $error("forced dcd");
  a_cts_forced: assert property ($stable(cts_ff) [*3]
    ##0 cts_ff != 2'b10 |-> dte_cts == (cts_ff == 2'b01))
    else $error("forced cts");
  a_dcd_track: assert property ((dcd_ff == 2'b10 && far_rts) [*5]
    |-> dte_dcd) else $error("dcd not following far rts");
  a_cts_fall: assert property (cts_ff == 2'b10 && $fell(dte_rts)
    |-> ##[1:4] !dte_cts) else $error("cts held after rts fall");
  c_cts_on: cover property (cts_ff == 2'b10 && $rose(dte_cts));
  c_dcd_off: cover property (dcd_ff == 2'b10 && $fell(dte_dcd));
  c_both: cover property (local_loop && net_loop);
endmodule : dte_ctl_chk

bind dte_control_signal_loopback dte_ctl_chk #(
  .LOOP_TIMEOUT_MS_P(LOOP_TIMEOUT_MS_P),
  .MS_CYCLES_P(MS_CYCLES_P)
) chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .far_rts(far_rts), .dte_rts(dte_rts),
  .panel_ll_sw(panel_ll_sw), .ring_det(ring_det), .dte_dcd(dte_dcd),
  .dte_dsr(dte_dsr), .dte_cts(dte_cts), .dte_ri(dte_ri),
  .local_loop(local_loop), .net_loop(net_loop),
  .remote_loop(remote_loop), .console_en(console_en),
  .rate_exact(rate_exact), .char_frame(char_frame));

//--- testbench/dte_model.sv
module dte_model
(
  input  wire logic clk_sys,    // clock
  input  wire logic rts_want,   // raise rts
  input  wire logic ll_want,    // ask local loop
  input  wire logic rl_want,    // ask remote loop
  output logic      dte_rts,    // rts pin
  output logic      dte_ll_req, // local loop pin
  output logic      dte_rl_req  // remote loop pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // terminal pins, changed just after the edge
  // ==========================================================
  initial
  begin
    dte_rts    = 1'b0;
    dte_ll_req = 1'b0;
    dte_rl_req = 1'b0;
  end
  always @(posedge clk_sys)
  begin
    dte_rts    <= rts_want;
    dte_ll_req <= ll_want;
    dte_rl_req <= rl_want;
  end
endmodule : dte_model

//--- testbench/dte_control_signal_loopback_tb.sv
module dte_control_signal_loopback_tb
  import dte_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 3;
  localparam int BIT_CYC = DIV + 1;
  localparam int MSC = 10;
  logic        clk_sys, sys_rst, reg_wr, reg_rd, far_rts, panel_ll_sw;
  logic        ring_det, rts_want, ll_want, rl_want;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic        dte_rts, dte_ll_req, dte_rl_req, dte_dcd, dte_dsr, dte_cts;
  logic        dte_ri, local_loop, net_loop, remote_loop, console_en;
  logic        rate_exact, bit_tick;
  logic [2:0]  char_frame;
  integer      seed = 32'hfd40;
  int          fail_count = 0;
  int          checked = 0;
  int          n;
  logic [7:0]  ra [7] = '{ADDR_DCD_CFG, ADDR_CTS_CFG, ADDR_MISC_CFG,
    ADDR_LOOP_CMD, ADDR_STATUS, ADDR_RATE_CFG, 8'h20};
  logic [31:0] re [7] = '{RST_DCD_CFG, RST_CTS_CFG, RST_MISC_CFG,
    RST_LOOP_CMD, 32'h34, {16'h0, RST_BIT_DIV}, 32'h0};
  int          dq [5] = '{0, 52, 80, 127, 33};
  int          cq [8] = '{0, 52, 60, 7, 52, 250, 300, 23};
  logic        cu [8] = '{0, 0, 0, 1, 1, 1, 1, 0};

  dte_control_signal_loopback #(.LOOP_TIMEOUT_MS_P(5), .MS_CYCLES_P(MSC))
  dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .far_rts(far_rts), .dte_rts(dte_rts),
    .dte_ll_req(dte_ll_req), .dte_rl_req(dte_rl_req),
    .panel_ll_sw(panel_ll_sw), .ring_det(ring_det), .dte_dcd(dte_dcd),
    .dte_dsr(dte_dsr), .dte_cts(dte_cts), .dte_ri(dte_ri),
    .local_loop(local_loop), .net_loop(net_loop),
    .remote_loop(remote_loop), .console_en(console_en),
    .rate_exact(rate_exact), .char_frame(char_frame), .bit_tick(bit_tick));
  dte_model dte_u (.clk_sys(clk_sys), .rts_want(rts_want),
    .ll_want(ll_want), .rl_want(rl_want), .dte_rts(dte_rts),
    .dte_ll_req(dte_ll_req), .dte_rl_req(dte_rl_req));

  always #5 clk_sys = ~clk_sys;
  // ==========================================================
  // helpers
  // ==========================================================
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : tick
  function automatic logic pick(input int sel);
    return (sel == 0) ? dte_dcd : dte_cts;
  endfunction : pick
  // waits for a level, counting whole cycles
  task automatic meas(input int sel, input logic val, output int cnt);
    cnt = 0;
    while (pick(sel) !== val && cnt < 4000)
    begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end
    if (cnt >= 4000)
    begin
      fail_count++;
      stop_test();
    end
  endtask : meas
  function automatic int dcd_round(input int r);
    if (r > DCD_MAX_BITS) return DCD_MAX_BITS;
    if (r < DCD_MIN_BITS) return DCD_MIN_BITS;
    return ((r + DCD_STEP_BITS - 1) / DCD_STEP_BITS) * DCD_STEP_BITS;
  endfunction : dcd_round
  function automatic int cts_cyc(input int r, input logic ms);
    int s [7] = '{10, 20, 30, 40, 50, 100, 250};
    if (!ms)
      return (r > CTS_MAX_BITS ? CTS_MAX_BITS : (r + 9) / 10 * 10) * BIT_CYC;
    foreach (s[i])
      if (r <= s[i]) return s[i] * MSC;
    return 250 * MSC;
  endfunction : cts_cyc
  function automatic logic [31:0] near(input int c, input int e, int t);
    return {31'h0, (c >= e - t) && (c <= e + t)};
  endfunction : near
  // ==========================================================
  // main sequence
  // ==========================================================
  initial
  begin
    {clk_sys, reg_wr, reg_rd, far_rts, panel_ll_sw, ring_det} = '0;
    {rts_want, ll_want, rl_want, reg_addr, reg_wdata} = '0;
    sys_rst = 1'b1;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    chk({dte_dcd, dte_dsr, dte_cts, dte_ri, net_loop}, 5'b11100);
    foreach (ra[i])
    begin
      rd(ra[i], rv);
      chk(rv, re[i]);
    end
    wr(ADDR_LOOP_CMD, 32'h0);
    rd(ADDR_LOOP_CMD, rv);
    chk(rv, RST_LOOP_CMD);
    $display("test reset done");
    wr(ADDR_RATE_CFG, DIV);
    wr(ADDR_DCD_CFG, 32'h3402);
    n = 0;
    repeat (2 * BIT_CYC)
    begin
      tick(1);
      n += bit_tick;
    end
    chk(n, 2);
    @(posedge clk_sys);
    far_rts <= 1'b1;
    tick(8);
    @(posedge clk_sys);
    far_rts <= 1'b0;
    tick(8);
    @(posedge clk_sys);
    far_rts <= 1'b1;
    tick(200);
    chk(dte_dcd, 1'b1);
    dq[4] = $unsigned($random(seed)) % 128;
    foreach (dq[i])
    begin
      wr(ADDR_DCD_CFG, 32'((dq[i] << DCD_DLY_LSB) | 2));
      tick(8);
      chk(dte_dcd, 1'b1);
      @(posedge clk_sys);
      far_rts <= 1'b0;
      meas(0, 1'b0, n);
      chk(near(n, dcd_round(dq[i]) * BIT_CYC, 10), 1);
      @(posedge clk_sys);
      far_rts <= 1'b1;
    end
    wr(ADDR_DCD_CFG, 32'h0);
    tick(4);
    chk(dte_dcd, 1'b0);
    $display("test carrier done");
    cq[7] = $unsigned($random(seed)) % 70;
    foreach (cq[i])
    begin
      wr(ADDR_CTS_CFG, 32'((cq[i] << CTS_DLY_LSB) | (cu[i] << 2) | 2));
      tick(4);
      chk(dte_cts, 1'b0);
      @(posedge clk_sys);
      rts_want <= 1'b1;
      meas(1, 1'b1, n);
      chk(near(n, cts_cyc(cq[i], cu[i]), 14), 1);
      @(posedge clk_sys);
      rts_want <= 1'b0;
      meas(1, 1'b0, n);
      chk(n < 8, 1);
    end
    wr(ADDR_CTS_CFG, 32'h0);
    @(posedge clk_sys);
    rts_want <= 1'b1;
    tick(60);
    chk(dte_cts, 1'b0);
    @(posedge clk_sys);
    rts_want <= 1'b0;
    $display("test clear done");
    repeat (6)
    begin
      rv = $random(seed);
      wr(ADDR_MISC_CFG, {21'h0, rv[10:0]});
      ring_det <= rv[12];
      tick(6);
      chk({dte_dsr, rate_exact, dte_ri, console_en, char_frame},
        {rv[0], rv[1], rv[2] & rv[12], rv[4],
        (rv[10:8] > FRAME_ASY11) ? FRAME_SYNC : rv[10:8]});
    end
    wr(ADDR_MISC_CFG, RST_MISC_CFG | 32'h700);
    tick(4);
    chk(char_frame, FRAME_SYNC);
    $display("test options done");
    wr(ADDR_MISC_CFG, RST_MISC_CFG);
    ll_want <= 1'b1;
    rl_want <= 1'b1;
    tick(6);
    chk({local_loop, remote_loop}, 2'b10);
    rd(ADDR_STATUS, rv);
    chk(rv[1:0], LOOP_LOC);
    wr(ADDR_MISC_CFG, RST_MISC_CFG & 32'hfffffff7);
    tick(6);
    chk(local_loop, 1'b0);
    @(posedge clk_sys);
    ll_want <= 1'b0;
    panel_ll_sw <= 1'b1;
    tick(6);
    chk(local_loop, 1'b1);
    wr(ADDR_LOOP_CMD, 32'h1);
    tick(4);
    chk(net_loop, 1'b1);
    rd(ADDR_STATUS, rv);
    chk(rv[1:0], LOOP_LOC_NET);
    tick(80);
    chk({local_loop, net_loop}, 2'b10);
    rd(ADDR_STATUS, rv);
    chk(rv[3], 1'b1);
    @(posedge clk_sys);
    panel_ll_sw <= 1'b0;
    wr(ADDR_LOOP_CMD, 32'h0);
    tick(6);
    chk({local_loop, net_loop}, 2'b00);
    wr(ADDR_LOOP_CMD, 32'h1);
    tick(30);
    chk(net_loop, 1'b1);
    tick(40);
    chk(net_loop, 1'b0);
    $display("test loops done");
    stop_test();
  end
endmodule : dte_control_signal_loopback_tb
